// ==== rtl/imeec_cfg.svh ====
// Offsets, field positions, reset values and codes for the exception entry block
`ifndef IMEEC_CFG_SVH
`define IMEEC_CFG_SVH
// Register byte offsets
`define IMEEC_OFF_MODE      8'h00
`define IMEEC_OFF_SENSE     8'h04
`define IMEEC_OFF_ENABLE    8'h08
`define IMEEC_OFF_STATUS    8'h0C
`define IMEEC_OFF_PRIO0     8'h10
`define IMEEC_OFF_PRIO1     8'h14
`define IMEEC_OFF_PRIO2     8'h18
`define IMEEC_OFF_PRIO3     8'h1C
`define IMEEC_OFF_ROUTE     8'h20
`define IMEEC_OFF_CPUSTAT   8'h24
// Mode control field positions
`define IMEEC_MODE_LO_BIT   4
`define IMEEC_NMI_EDGE_BIT  3
// Reset values
`define IMEEC_MODE_RST      8'h00
`define IMEEC_SENSE_RST     32'h0000_0000
`define IMEEC_ENABLE_RST    32'h0000_0000
`define IMEEC_PRIO_RST      16'h7777
`define IMEEC_ROUTE_RST     32'h0000_0000
// Sense codes per request pin
`define IMEEC_SENSE_LEVEL   2'h0
`define IMEEC_SENSE_FALL    2'h1
`define IMEEC_SENSE_RISE    2'h2
`define IMEEC_SENSE_BOTH    2'h3
// Vector numbers
`define IMEEC_VEC_ILLEGAL   8'h04
`define IMEEC_VEC_NMI       8'h07
`define IMEEC_VEC_IRQ_BASE  8'h10
// Undefined operation field range
`define IMEEC_ILL_OP_LO     8'h58
`define IMEEC_ILL_OP_HI     8'h5F
// Status bit positions in the flag bytes
`define IMEEC_CCR_I_BIT     7
`define IMEEC_EXR_T_BIT     7
`endif

// ==== rtl/imeec_pkg.sv ====
// Types shared by the exception entry block
package imeec_pkg;
  // Control modes; 01 and 11 are never stored
  typedef enum logic [1:0] {
    IMEEC_MODE0 = 2'h0,
    IMEEC_MODE2 = 2'h2
  } imeec_mode_t;

  // Entry sequencer, one-hot
  typedef enum logic [4:0] {
    IMEEC_S_IDLE = 5'h01,
    IMEEC_S_PUSH_PC = 5'h02,
    IMEEC_S_PUSH_FL = 5'h04,
    IMEEC_S_VEC = 5'h08,
    IMEEC_S_LOAD = 5'h10
  } imeec_state_t;

  // Core context seen and reloaded by the sequencer
  typedef struct packed {
    logic [31:0] pc;
    logic [31:0] sp;
    logic [7:0]  condition_flags;
    logic [7:0]  extended_status_register;
  } imeec_cpu_state_t;

  // Memory request to the core's bus unit
  typedef struct packed {
    logic        req;
    logic        we;
    logic [31:0] addr;
    logic [31:0] wdata;
  } imeec_mem_req_t;
endpackage

// ==== rtl/imeec_sense.sv ====
// Request pin sense detector: level, falling, rising or both edges
`timescale 1ns/1ps
`include "imeec_cfg.svh"
module imeec_sense
  import imeec_pkg::*;
(
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       pin_n,
  input  wire logic [1:0] sense,
  output logic            det
);
  logic prev_q;
  logic prev_d;

  // Previous level; idles high so reset gives no false edge
  always_comb
  begin
    prev_d = pin_n;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prev_q <= 1'b1;
    else
      prev_q <= prev_d;
  end

  // Event decode
  always_comb
  begin
    case (sense)
      `IMEEC_SENSE_LEVEL: det = ~pin_n;
      `IMEEC_SENSE_FALL:  det = prev_q & ~pin_n;
      `IMEEC_SENSE_RISE:  det = ~prev_q & pin_n;
      default:            det = prev_q ^ pin_n;
    endcase
  end
endmodule // imeec_sense

// ==== rtl/imeec_top.sv ====
// Exception entry sequencer and interrupt controller front end
//
// The address map and the APB interface to the registers were decided locally.
`timescale 1ns/1ps
`include "imeec_cfg.svh"
// Overview of operation
// - Illegal opcode detected in execution state starts exception entry at once.
// - Entry first pushes program counter, then condition and extended flags.
// - Then mask updated, trace cleared in mode 2, vector fetched and loaded into PC.
// - Illegal entry sets global mask; clears trace in mode 2 only.
// - Detector looks at operation field only, not registers or extensions.
// - Each code word is checked alone; combinations are never flagged.
// - Word and longword addresses have their lowest bit forced to 0.
// - Mode field 00 selects mode 0, 10 mode 2; 01 and 11 prohibited.
// - Each maskable source gets one of eight priority levels.
// - Nonmaskable request ranks level 8 and is always accepted.
// - Every source has its own vector number.
// - Bit 3 of mode control selects nonmaskable request edge.
// - Each request pin senses falling, rising, both edges or level; two sets.
// - Block transfer and memory engines are started by routed requests.
// - Mode control bits 7,6 and 2..0 read zero; all reset to zero.
// - After reset the controller runs in control mode 0.
// - Priority fields are three bits, 000 lowest to 111 highest.
module imeec_top
  import imeec_pkg::*;
(
  input  wire logic             pclk,
  input  wire logic             presetn,
  input  wire logic             psel,
  input  wire logic             penable,
  input  wire logic             pwrite,
  input  wire logic [7:0]       paddr,
  input  wire logic [31:0]      pwdata,
  output logic [31:0]           prdata,
  output logic                  pready,
  output logic                  pslverr,
  input  wire logic             nmi_n,
  input  wire logic [15:0]      request_pin_set_a,
  input  wire logic [15:0]      request_pin_set_b,
  input  wire logic             instr_word_valid,
  input  wire logic [15:0]      instr_word,
  input  wire logic             instr_ext_word,
  input  wire logic             exec_state,
  input  wire logic             insn_boundary,
  input  wire imeec_cpu_state_t cpu_state,
  output imeec_mem_req_t        mem_out,
  input  wire logic             mem_ack,
  input  wire logic [31:0]      mem_rdata,
  output logic                  exc_active,
  output logic                  ctx_load,
  output imeec_cpu_state_t      ctx_out,
  output logic [15:0]           btc_req,
  input  wire logic [15:0]      btc_ack,
  output logic [15:0]           dma_req,
  input  wire logic [15:0]      dma_ack,
  output logic [1:0]            control_mode
);
  // ****************************************************************
  // Register file
  // ****************************************************************
  logic [7:0]  mode_q, mode_d;
  logic [31:0] sense_q, sense_d;
  logic [31:0] enable_q, enable_d;
  logic [15:0] prio_q [4];
  logic [15:0] prio_d [4];
  logic [31:0] route_q, route_d;
  logic [31:0] rdata_q, rdata_d;
  logic [15:0] flag_q, flag_d;
  logic        nmi_q, nmi_d;
  logic        ill_q, ill_d;
  logic        wr_en, setup;
  logic        hit;
  logic [31:0] rmux;

  assign setup   = psel & ~penable;
  assign wr_en   = psel & penable & pwrite;
  assign pready  = 1'b1;
  assign pslverr = psel & penable & ~hit;

  // Address decode and read mux
  always_comb
  begin
    hit  = 1'b1;
    rmux = 32'h0000_0000;
    case (paddr)
      `IMEEC_OFF_MODE:    rmux = {24'h00_0000, mode_q};
      `IMEEC_OFF_SENSE:   rmux = sense_q;
      `IMEEC_OFF_ENABLE:  rmux = enable_q;
      `IMEEC_OFF_STATUS:  rmux = {15'h0000, nmi_q, flag_q};
      `IMEEC_OFF_PRIO0:   rmux = {16'h0000, prio_q[0]};
      `IMEEC_OFF_PRIO1:   rmux = {16'h0000, prio_q[1]};
      `IMEEC_OFF_PRIO2:   rmux = {16'h0000, prio_q[2]};
      `IMEEC_OFF_PRIO3:   rmux = {16'h0000, prio_q[3]};
      `IMEEC_OFF_ROUTE:   rmux = route_q;
      `IMEEC_OFF_CPUSTAT: rmux = {16'h0000, cpu_state.condition_flags, cpu_state.extended_status_register};
      default:            hit = 1'b0;
    endcase
  end

  // Register writes; read data captured in the setup phase
  always_comb
  begin
    mode_d   = mode_q;
    sense_d  = sense_q;
    enable_d = enable_q;
    route_d  = route_q;
    for (int k = 0; k < 4; k++)
      prio_d[k] = prio_q[k];
    rdata_d  = setup ? rmux : rdata_q;
    if (wr_en)
    begin
      case (paddr)
        `IMEEC_OFF_MODE:
        begin
          // Prohibited mode codes leave the old mode in place
          if (pwdata[`IMEEC_MODE_LO_BIT] == 1'b0)
            mode_d[`IMEEC_MODE_LO_BIT+1] = pwdata[`IMEEC_MODE_LO_BIT+1];
          mode_d[`IMEEC_NMI_EDGE_BIT] = pwdata[`IMEEC_NMI_EDGE_BIT];
        end
        `IMEEC_OFF_SENSE:  sense_d  = pwdata;
        `IMEEC_OFF_ENABLE: enable_d = pwdata;
        `IMEEC_OFF_PRIO0:  prio_d[0] = pwdata[15:0] & 16'h7777;
        `IMEEC_OFF_PRIO1:  prio_d[1] = pwdata[15:0] & 16'h7777;
        `IMEEC_OFF_PRIO2:  prio_d[2] = pwdata[15:0] & 16'h7777;
        `IMEEC_OFF_PRIO3:  prio_d[3] = pwdata[15:0] & 16'h7777;
        `IMEEC_OFF_ROUTE:  route_d  = pwdata;
        default:           mode_d   = mode_q;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      mode_q   <= `IMEEC_MODE_RST;
      sense_q  <= `IMEEC_SENSE_RST;
      enable_q <= `IMEEC_ENABLE_RST;
      route_q  <= `IMEEC_ROUTE_RST;
      rdata_q  <= 32'h0000_0000;
      for (int k = 0; k < 4; k++)
        prio_q[k] <= `IMEEC_PRIO_RST;
    end
    else
    begin
      mode_q   <= mode_d;
      sense_q  <= sense_d;
      enable_q <= enable_d;
      route_q  <= route_d;
      rdata_q  <= rdata_d;
      for (int k = 0; k < 4; k++)
        prio_q[k] <= prio_d[k];
    end
  end

  assign prdata       = rdata_q;
  assign control_mode = mode_q[`IMEEC_MODE_LO_BIT+1 -: 2];

  // ****************************************************************
  // Request detection
  // ****************************************************************
  logic [15:0] det;
  logic        nmi_det;
  logic [15:0] pins_n;

  // Set B chosen per pin by the upper enable half; a swap can fake an edge
  assign pins_n = (request_pin_set_b & enable_q[31:16])
                | (request_pin_set_a & ~enable_q[31:16]);

  for (genvar g = 0; g < 16; g++)
  begin : g_sense
    imeec_sense u_sense (
      .pclk    (pclk),
      .presetn (presetn),
      .pin_n   (pins_n[g]),
      .sense   (sense_q[2*g +: 2]),
      .det     (det[g])
    );
  end

  imeec_sense u_nmi (
    .pclk    (pclk),
    .presetn (presetn),
    .pin_n   (nmi_n),
    .sense   (mode_q[`IMEEC_NMI_EDGE_BIT] ? `IMEEC_SENSE_RISE
                                          : `IMEEC_SENSE_FALL),
    .det     (nmi_det)
  );

  // ****************************************************************
  // Arbitration
  // ****************************************************************
  imeec_state_t st_q, st_d;
  logic [2:0]  lvl [16];
  logic [15:0] cand;
  logic        irq_ok;
  logic [3:0]  best_idx;
  logic [2:0]  best_lvl;
  logic        ill_word;
  logic        take_ill, take_nmi, take_irq, start;

  // Sources routed to an engine never interrupt the core
  assign cand = flag_q & enable_q[15:0] & ~route_q[15:0] & ~route_q[31:16];
  assign btc_req = flag_q & enable_q[15:0] & route_q[15:0];
  assign dma_req = flag_q & enable_q[15:0] & route_q[31:16] & ~route_q[15:0];

  // Highest level wins; lower index wins a tie
  always_comb
  begin
    best_idx = 4'h0;
    best_lvl = 3'h0;
    irq_ok   = 1'b0;
    for (int i = 0; i < 16; i++)
    begin
      lvl[i] = prio_q[i/4][4*(i%4) +: 3];
      if (cand[i] && (!irq_ok || lvl[i] > best_lvl))
      begin
        irq_ok   = 1'b1;
        best_idx = 4'(i);
        best_lvl = lvl[i];
      end
    end
    // Mode gate: mode 0 global mask, mode 2 level above mask
    if (control_mode == IMEEC_MODE2)
      irq_ok = irq_ok & (best_lvl > cpu_state.extended_status_register[2:0]);
    else
      irq_ok = irq_ok & ~cpu_state.condition_flags[`IMEEC_CCR_I_BIT];
  end

  // Only the operation field is decoded; register bits and extensions skipped
  assign ill_word = instr_word_valid & ~instr_ext_word & exec_state
                  & (instr_word[15:8] >= `IMEEC_ILL_OP_LO)
                  & (instr_word[15:8] <= `IMEEC_ILL_OP_HI);

  assign start    = (st_q == IMEEC_S_IDLE);
  assign take_ill = start & ill_q;
  assign take_nmi = start & ~ill_q & nmi_q & insn_boundary;
  assign take_irq = start & ~ill_q & ~nmi_q & insn_boundary & irq_ok;

  // Pending flags: a new event beats a clear in the same cycle
  always_comb
  begin
    logic [15:0] clr;
    clr = btc_ack | dma_ack;
    if (wr_en && paddr == `IMEEC_OFF_STATUS)
      clr = clr | pwdata[15:0];
    for (int i = 0; i < 16; i++)
      if (take_irq && best_idx == 4'(i) && sense_q[2*i +: 2] != `IMEEC_SENSE_LEVEL)
        clr[i] = 1'b1;
    flag_d = (flag_q & ~clr) | det;
    nmi_d  = (nmi_q & ~take_nmi) | nmi_det;
    ill_d  = (ill_q & ~take_ill) | ill_word;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      flag_q <= 16'h0000;
      nmi_q  <= 1'b0;
      ill_q  <= 1'b0;
    end
    else
    begin
      flag_q <= flag_d;
      nmi_q  <= nmi_d;
      ill_q  <= ill_d;
    end
  end

  // ****************************************************************
  // Entry sequencer
  // ****************************************************************
  imeec_cpu_state_t ctx_q, ctx_d;
  imeec_mem_req_t   mem_q, mem_d;
  logic [31:0]      base_sp;

  assign base_sp = {cpu_state.sp[31:1], 1'b0};

  always_comb
  begin
    logic [7:0] vec;
    vec   = `IMEEC_VEC_ILLEGAL;
    st_d  = st_q;
    ctx_d = ctx_q;
    mem_d = mem_q;
    case (st_q)
      IMEEC_S_IDLE:
      begin
        if (take_ill || take_nmi || take_irq)
        begin
          ctx_d     = cpu_state;
          ctx_d.sp  = base_sp - 32'h0000_0008;
          ctx_d.condition_flags[`IMEEC_CCR_I_BIT] = 1'b1;
          if (control_mode == IMEEC_MODE2)
          begin
            ctx_d.extended_status_register[`IMEEC_EXR_T_BIT] = 1'b0;
            if (take_nmi)
              ctx_d.extended_status_register[2:0] = 3'h7;
            else if (take_irq)
              ctx_d.extended_status_register[2:0] = best_lvl;
          end
          if (take_nmi)
            vec = `IMEEC_VEC_NMI;
          else if (take_irq)
            vec = `IMEEC_VEC_IRQ_BASE + {4'h0, best_idx};
          // Vector kept in pc until the fetch phase
          ctx_d.pc[31:8] = 24'h00_0000;
          ctx_d.pc[7:0]  = vec;
          mem_d = '{1'b1, 1'b1, base_sp - 32'h0000_0004,
                    {cpu_state.pc[31:1], 1'b0}};
          st_d  = IMEEC_S_PUSH_PC;
        end
      end
      IMEEC_S_PUSH_PC:
      begin
        if (mem_ack)
        begin
          mem_d = '{1'b1, 1'b1, base_sp - 32'h0000_0008,
                    {16'h0000, cpu_state.condition_flags, cpu_state.extended_status_register}};
          st_d  = IMEEC_S_PUSH_FL;
        end
      end
      IMEEC_S_PUSH_FL:
      begin
        if (mem_ack)
        begin
          mem_d = '{1'b1, 1'b0, {22'h00_0000, ctx_q.pc[7:0], 2'h0},
                    32'h0000_0000};
          st_d  = IMEEC_S_VEC;
        end
      end
      IMEEC_S_VEC:
      begin
        if (mem_ack)
        begin
          mem_d     = '0;
          ctx_d.pc  = {mem_rdata[31:1], 1'b0};
          st_d      = IMEEC_S_LOAD;
        end
      end
      IMEEC_S_LOAD:
        st_d = IMEEC_S_IDLE;
      default:
      begin
        st_d  = IMEEC_S_IDLE;
        mem_d = '0;
      end
    endcase
  end

  // Core holds its own sp stable while entry is active
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      st_q  <= IMEEC_S_IDLE;
      ctx_q <= '0;
      mem_q <= '0;
    end
    else
    begin
      st_q  <= st_d;
      ctx_q <= ctx_d;
      mem_q <= mem_d;
    end
  end

  assign mem_out    = mem_q;
  assign ctx_out    = ctx_q;
  assign ctx_load   = (st_q == IMEEC_S_LOAD);
  assign exc_active = (st_q != IMEEC_S_IDLE);
endmodule // imeec_top

// ==== sim/imeec_monitor.sv ====
// Port-level checker for the exception entry block
`timescale 1ns/1ps
module imeec_monitor
  import imeec_pkg::*;
(
  input wire logic             pclk,
  input wire logic             presetn,
  input wire logic             psel,
  input wire logic             penable,
  input wire logic             pwrite,
  input wire logic [7:0]       paddr,
  input wire logic [31:0]      pwdata,
  input wire logic [31:0]      prdata,
  input wire logic             pslverr,
  input wire logic             instr_word_valid,
  input wire logic [15:0]      instr_word,
  input wire logic             instr_ext_word,
  input wire logic             exec_state,
  input wire imeec_cpu_state_t cpu_state,
  input wire imeec_mem_req_t   mem_out,
  input wire logic             exc_active,
  input wire logic             ctx_load,
  input wire imeec_cpu_state_t ctx_out,
  input wire logic [15:0]      btc_req,
  input wire logic [15:0]      dma_req,
  input wire logic [1:0]       control_mode
);
  // ****
  // Properties, one clock domain
  // ****
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  a_mode_legal: assert property (control_mode == 2'h0 || control_mode == 2'h2)
    else $error("control mode holds a prohibited code");
  a_mode_write: assert property (psel && penable && pwrite && paddr == 8'h00 && !pwdata[4]
    |=> control_mode == $past(pwdata[5:4]))
    else $error("mode write not taken");
  a_mode_read: assert property (psel && !penable && !pwrite && paddr == 8'h00
    |=> prdata[31:6] == 26'h000_0000 && prdata[2:0] == 3'h0 && prdata[5:4] == $past(control_mode))
    else $error("mode readback wrong");
  a_addr_even: assert property (mem_out.req |-> !mem_out.addr[0])
    else $error("odd memory address");
  a_push_pc: assert property ($rose(exc_active) |-> mem_out.req && mem_out.we
    && mem_out.wdata == cpu_state.pc && mem_out.addr == {cpu_state.sp[31:1], 1'b0} - 32'h0000_0004)
    else $error("first push is not the program counter");
  a_ctx_mask: assert property (ctx_load |-> ctx_out.condition_flags[7] && !ctx_out.pc[0])
    else $error("reload without global mask");
  a_illegal_take: assert property (instr_word_valid && exec_state && !instr_ext_word
    && instr_word[15:11] == 5'h0B && !exc_active |-> ##[1:4] exc_active)
    else $error("illegal code not taken");
  a_route_excl: assert property ((btc_req & dma_req) == 16'h0000)
    else $error("one source routed to both engines");

  c_mode2_entry: cover property (ctx_load && control_mode == 2'h2);
  c_refused: cover property (psel && penable && pslverr);
  c_routed: cover property (btc_req != 16'h0000);
endmodule // imeec_monitor

bind imeec_top imeec_monitor u_mon (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pslverr(pslverr),
  .instr_word_valid(instr_word_valid), .instr_word(instr_word),
  .instr_ext_word(instr_ext_word), .exec_state(exec_state), .cpu_state(cpu_state),
  .mem_out(mem_out), .exc_active(exc_active), .ctx_load(ctx_load), .ctx_out(ctx_out),
  .btc_req(btc_req), .dma_req(dma_req), .control_mode(control_mode)
);

// ==== sim/imeec_mem_model.sv ====
// Core-side memory answering stack pushes and vector fetches
`timescale 1ns/1ps
module imeec_mem_model
  import imeec_pkg::*;
(
  input  wire logic           pclk,
  input  wire logic           presetn,
  input  wire logic           slow,
  input  wire imeec_mem_req_t mem_out,
  output logic                mem_ack,
  output logic [31:0]         mem_rdata
);
  logic        wait_q;
  logic        wait_d;
  logic        ack_d;
  logic [15:0] cyc_q;

  // One acknowledge per request; slow mode inserts a wait cycle
  always_comb
  begin
    ack_d  = 1'b0;
    wait_d = 1'b0;
    if (mem_out.req && !mem_ack)
    begin
      ack_d  = wait_q || !slow;
      wait_d = !ack_d;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      wait_q  <= 1'b0;
      mem_ack <= 1'b0;
      cyc_q   <= 16'h0000;
    end
    else
    begin
      wait_q  <= wait_d;
      mem_ack <= ack_d;
      cyc_q   <= cyc_q + 16'h0001;
    end
  end

  // Odd handler address shows the low bit is dropped; bus churns when idle
  assign mem_rdata = mem_ack ? {mem_out.addr[23:0], 8'h01} : {cyc_q, ~cyc_q};
endmodule // imeec_mem_model

// ==== sim/interrupt_mode_and_exception_entry_tb_top.sv ====
// Self-checking bench for the exception entry block
`timescale 1ns/1ps
module interrupt_mode_and_exception_entry_tb_top;
  import imeec_pkg::*;
  typedef struct packed {
    logic        we;
    logic [7:0]  addr;
    logic [31:0] data;
    logic        err;
  } imeec_row_t;

  // ****
  // Signals
  // ****
  logic             pclk = 1'b0, presetn = 1'b0, slow = 1'b0;
  logic             psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr, err;
  logic [7:0]       paddr = 8'h00;
  logic [31:0]      pwdata = 32'h0000_0000, prdata, rd, mem_rdata;
  logic             nmi_n = 1'b1, iw_valid = 1'b0, iw_ext = 1'b0, exec = 1'b1;
  logic [15:0]      pins_a = 16'hFFFF, iw = 16'h0000, btc_ack = 16'h0000, btc_req, dma_req;
  logic [15:0]      pins_b = 16'hFFFF;
  // Even stack pointer; the core keeps its context steady during entry
  imeec_cpu_state_t cpu = '{32'h0000_1234, 32'h0000_2000, 8'h00, 8'h83};
  imeec_cpu_state_t ctx_out;
  imeec_mem_req_t   mem_out;
  logic             mem_ack, exc_active, ctx_load;
  logic [1:0]       control_mode;
  logic [63:0]      pushes[$];
  int               err_total = 0, samples_checked = 0, cyc = 0;
  imeec_row_t       rows [10] = '{
    '{1'b0, 8'h00, 32'h0000_0000, 1'b0}, '{1'b0, 8'h10, 32'h0000_7777, 1'b0},
    '{1'b1, 8'h00, 32'h0000_00FF, 1'b0}, '{1'b0, 8'h00, 32'h0000_0008, 1'b0},
    '{1'b1, 8'h00, 32'h0000_0020, 1'b0}, '{1'b0, 8'h00, 32'h0000_0020, 1'b0},
    '{1'b1, 8'h40, 32'h0000_0020, 1'b1}, '{1'b0, 8'h40, 32'h0000_0000, 1'b1},
    '{1'b1, 8'h10, 32'h0000_89AB, 1'b0}, '{1'b0, 8'h10, 32'h0000_0123, 1'b0}};

  imeec_top u_dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .nmi_n(nmi_n), .request_pin_set_a(pins_a), .request_pin_set_b(pins_b),
    .instr_word_valid(iw_valid), .instr_word(iw), .instr_ext_word(iw_ext),
    .exec_state(exec), .insn_boundary(1'b1), .cpu_state(cpu), .mem_out(mem_out),
    .mem_ack(mem_ack), .mem_rdata(mem_rdata), .exc_active(exc_active), .ctx_load(ctx_load),
    .ctx_out(ctx_out), .btc_req(btc_req), .btc_ack(btc_ack), .dma_req(dma_req),
    .dma_ack(16'h0000), .control_mode(control_mode));

  imeec_mem_model u_mem (.pclk(pclk), .presetn(presetn), .slow(slow), .mem_out(mem_out),
    .mem_ack(mem_ack), .mem_rdata(mem_rdata));

  // Clock and a hang guard well beyond the expected run
  always #5 pclk = ~pclk;
  always @(posedge pclk)
  begin
    cyc++;
    if (cyc == 4000)
    begin
      err_total++;
      $display("[FAIL] %0t run timed out", $time);
      complete_run();
    end
  end

  // ****
  // Tasks
  // ****
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      err_total++;
      $display("[FAIL] %0t got %h want %h", $time, got, exp);
    end
  endtask

  // Entered just after a rising edge; one idle edge after, so psel never toggles twice
  task automatic apb(input logic we, input logic [7:0] a, input logic [31:0] d);
    psel   <= 1'b1;
    pwrite <= we;
    paddr  <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
      @(posedge pclk);
    while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic issue(input logic [15:0] w, input logic ext);
    iw       <= w;
    iw_ext   <= ext;
    iw_valid <= 1'b1;
    @(posedge pclk);
    iw_valid <= 1'b0;
  endtask

  // Observe on falling edges, where registered outputs have settled
  task automatic take(input logic [7:0] v, input logic [7:0] exr_exp);
    int n;
    n = 0;
    pushes.delete();
    while (ctx_load !== 1'b1 && n < 200)
    begin
      @(negedge pclk);
      n++;
      if (mem_ack === 1'b1 && mem_out.we === 1'b1)
        pushes.push_back({mem_out.addr, mem_out.wdata});
    end
    check(32'(pushes.size()), 32'h0000_0002);
    check(pushes[0][63:32], cpu.sp - 32'h0000_0004);
    check(pushes[0][31:0], cpu.pc);
    check(pushes[1][63:32], cpu.sp - 32'h0000_0008);
    check(pushes[1][31:0], {16'h0000, cpu.condition_flags, cpu.extended_status_register});
    check(ctx_out.sp, cpu.sp - 32'h0000_0008);
    check(ctx_out.pc, 32'(v) << 10);
    check(32'({ctx_out.condition_flags, ctx_out.extended_status_register}), 32'({cpu.condition_flags | 8'h80, exr_exp}));
    @(posedge pclk);
  endtask

  task automatic quiet();
    repeat (6) @(negedge pclk);
    check(32'(exc_active), 32'h0000_0000);
    @(posedge pclk);
  endtask

  task automatic complete_run();
    if (err_total == 0 && samples_checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // ****
  // Sequence
  // ****
  initial
  begin
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    foreach (rows[i])
    begin
      apb(rows[i].we, rows[i].addr, rows[i].data);
      if (!rows[i].we)
        check(rd, rows[i].data);
      check(32'(err), 32'(rows[i].err));
    end
    issue(16'h5A3C, 1'b0);
    take(8'h04, 8'h03);
    issue(16'h5800, 1'b1);
    quiet();
    // Outside the execution state an undefined word is not taken
    exec <= 1'b0;
    issue(16'h5B00, 1'b0);
    quiet();
    exec <= 1'b1;
    nmi_n <= 1'b0;
    take(8'h07, 8'h07);
    nmi_n <= 1'b1;
    quiet();
    apb(1'b1, 8'h00, 32'h0000_0028);
    nmi_n <= 1'b0;
    quiet();
    nmi_n <= 1'b1;
    take(8'h07, 8'h07);
    apb(1'b1, 8'h00, 32'h0000_0000);
    slow <= 1'b1;
    issue(16'h5F00, 1'b0);
    take(8'h04, 8'h83);
    // Each sense code, request disabled so only the flag shows
    for (int c = 0; c < 4; c++)
    begin
      apb(1'b1, 8'h04, 32'(c));
      apb(1'b1, 8'h0C, 32'h0000_0001);
      pins_a[0] <= 1'b0;
      repeat (4) @(posedge pclk);
      apb(1'b0, 8'h0C, 32'h0000_0000);
      check(32'(rd[0]), 32'(c != 2));
      apb(1'b1, 8'h0C, 32'h0000_0001);
      pins_a[0] <= 1'b1;
      repeat (4) @(posedge pclk);
      apb(1'b0, 8'h0C, 32'h0000_0000);
      check(32'(rd[0]), 32'(c != 1));
    end
    apb(1'b1, 8'h04, 32'h0000_0005);
    apb(1'b1, 8'h0C, 32'h0000_0003);
    apb(1'b1, 8'h08, 32'h0000_0001);
    pins_a[0] <= 1'b0;
    take(8'h10, 8'h83);
    cpu.condition_flags <= 8'h80;
    // Source 1 from set B, routed to both engines; the block engine wins
    apb(1'b1, 8'h20, 32'h0002_0002);
    apb(1'b1, 8'h08, 32'h0002_0003);
    pins_b[1] <= 1'b0;
    repeat (4) @(negedge pclk);
    check(32'(btc_req), 32'h0000_0002);
    check(32'(dma_req), 32'h0000_0000);
    @(posedge pclk);
    btc_ack <= 16'h0002;
    @(posedge pclk);
    btc_ack <= 16'h0000;
    @(negedge pclk);
    check(32'(btc_req), 32'h0000_0000);
    @(posedge pclk);
    // Mode 2: source 0 at level 3 is held off by mask 3, taken under mask 2
    pins_a[0] <= 1'b1;
    apb(1'b1, 8'h00, 32'h0000_0020);
    pins_a[0] <= 1'b0;
    quiet();
    cpu.extended_status_register <= 8'h82;
    take(8'h10, 8'h03);
    apb(1'b1, 8'h00, 32'h0000_0028);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, 8'h00, 32'h0000_0000);
    check(rd, 32'h0000_0000);
    check(32'(control_mode), 32'h0000_0000);
    complete_run();
  end
endmodule // interrupt_mode_and_exception_entry_tb_top
